/* logic/shrm_pkg.sv */
package shrm_pkg;

    // Shared memory geometry
    localparam int SRAM_BYTES = 16384;
    localparam int SRAM_AW = 14;
    localparam int DEV_COUNT = 32;
    localparam int SEG_BYTES = 128;
    localparam int CFG_SEG_BYTES = 8;
    localparam logic [1:0] LOGOUT_MISSES = 2'h3;

    // Byte addresses of the map regions
    localparam logic [13:0] ADR_REQ_QUEUE = 14'h0000;
    localparam logic [13:0] ADR_REQ_HEAD = 14'h0880;
    localparam logic [13:0] ADR_REQ_TAIL = 14'h0881;
    localparam logic [13:0] ADR_SETUP = 14'h0882;
    localparam logic [13:0] ADR_STATUS = 14'h0892;
    localparam logic [13:0] ADR_INT_STATUS = 14'h08A2;
    localparam logic [13:0] ADR_INT_DISABLE = 14'h08B2;
    localparam logic [13:0] ADR_CMD_BLOCK = 14'h08C2;
    localparam logic [13:0] ADR_CMD_LAST = 14'h08D1;
    localparam logic [13:0] ADR_TX_DGRAM = 14'h08D2;
    localparam logic [13:0] ADR_RX_DGRAM = 14'h09C2;
    localparam logic [13:0] ADR_LOCK_REQ = 14'h0A48;
    localparam logic [13:0] ADR_LOCK_STATE = 14'h0A49;
    localparam logic [13:0] ADR_HOST_INT_CLR = 14'h0A4A;
    localparam logic [13:0] ADR_RESERVED = 14'h0A4B;
    localparam logic [13:0] ADR_DEV_CONFIG = 14'h1E00;
    localparam logic [13:0] ADR_DIR_IN = 14'h1F00;
    localparam logic [13:0] ADR_BCAST_OUT = 14'h1F80;
    localparam logic [13:0] ADR_DEV_INPUT = 14'h2000;
    localparam logic [13:0] ADR_DEV_OUTPUT = 14'h3000;

    // Byte positions inside the interrupt status table
    localparam logic [13:0] INT_DEV_CHANGE = 14'h0003;
    localparam logic [13:0] INT_LOCK_GRANT = 14'h0007;

    // Byte values written by the manager
    localparam logic [7:0] FLAG_SET = 8'h01;
    localparam logic [7:0] FLAG_CLR = 8'h00;

    // Manager interrupt source positions
    localparam int IRQ_HEAD = 0;
    localparam int IRQ_CMD = 1;
    localparam int IRQ_LOCK = 2;

    typedef enum logic [1:0] {
        LK_BCAST = 2'h0,
        LK_IDENT = 2'h1,
        LK_DIRECT = 2'h2,
        LK_SCAN = 2'h3
    } shrm_kind_t;

    // One received byte from the serial side
    typedef struct packed {
        shrm_kind_t kind;
        logic [4:0] dev;
        logic last;
        logic [7:0] data;
    } shrm_lnk_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_RX = 4'h1,
        ST_SCAN = 4'h2,
        ST_DEVCHG = 4'h3,
        ST_TX = 4'h4,
        ST_TXRD = 4'h5,
        ST_TXSEND = 4'h6,
        ST_LOCK = 4'h7,
        ST_GRANT = 4'h8,
        ST_UNLOCK = 4'h9
    } shrm_state_t;

endpackage : shrm_pkg

/* logic/shrm_core.sv */
`timescale 1ns/1ps
`default_nettype none

module shrm_fifo #(
    parameter int W = 16,
    parameter int D = 8
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = (D > 1) ? $clog2(D) : 1;
    logic [W-1:0] buf_r [D];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0] cnt_r;
    wire push = ce & in_valid & in_ready;
    wire pull = ce & out_valid & out_ready;

    assign in_ready = (cnt_r != (AW+1)'(D));
    assign out_valid = (cnt_r != '0);
    assign out_data = buf_r[rp_r];

    function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
        ptr_inc = (p == AW'(D - 1)) ? '0 : p + 1'b1;
    endfunction : ptr_inc

    always_ff @(posedge core_clk)
        if (push)
            buf_r[wp_r] <= in_data;

    always_ff @(posedge core_clk)
        if (!reset_n)
        begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end
        else
        begin
            if (push)
                wp_r <= ptr_inc(wp_r);
            if (pull)
                rp_r <= ptr_inc(rp_r);
            if (push & ~pull)
                cnt_r <= cnt_r + 1'b1;
            else if (pull & ~push)
                cnt_r <= cnt_r - 1'b1;
        end

    AST_FIFO_NO_OVERRUN: assert property (@(posedge core_clk) disable iff (!reset_n)
        cnt_r <= (AW+1)'(D)) else $error("fifo count above depth");
endmodule : shrm_fifo

module shrm_core #(
    parameter int FIFO_DEPTH = 8
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic hst_sel,
    input wire logic hst_wr,
    input wire logic [shrm_pkg::SRAM_AW-1:0] hst_addr,
    input wire logic [7:0] hst_wdata,
    output logic [7:0] hst_rdata,
    input wire logic lnk_valid,
    output logic lnk_ready,
    input wire shrm_pkg::shrm_lnk_t lnk_word,
    output logic tx_valid,
    input wire logic tx_ready,
    output logic [7:0] tx_data,
    output logic [4:0] tx_dev,
    output logic tx_own,
    output logic tx_last,
    output logic login_req,
    output logic [4:0] login_dev,
    output logic mgr_irq,
    output logic [2:0] mgr_irq_src,
    input wire logic [2:0] mgr_irq_ack,
    output logic lock_granted
);
    import shrm_pkg::*;

    logic [7:0] mem_r [SRAM_BYTES];
    logic [7:0] hst_q_r;
    logic [7:0] mgr_q_r;
    shrm_state_t st_r;
    shrm_state_t st_nxt;
    shrm_lnk_t w_r;
    logic [4:0] dev_r;
    logic [6:0] idx_r;
    logic own_r;
    logic lost_r;
    logic lock_req_r;
    logic lock_gnt_r;
    logic [31:0] logged_r;
    logic [31:0] seen_r;
    logic [1:0] miss_r [DEV_COUNT];
    logic [2:0] irq_src_r;
    logic login_req_r;
    logic [4:0] login_dev_r;

    shrm_lnk_t fifo_word;
    logic fifo_valid;

    function automatic logic [13:0] seg_addr(input logic [13:0] base, input logic [4:0] dev,
                                             input logic [6:0] idx, input logic wide);
        if (wide)
            seg_addr = base + {2'b0, dev, idx};
        else
            seg_addr = base + {6'b0, dev, idx[2:0]};
    endfunction : seg_addr

    wire lock_take = lock_req_r & ~lock_gnt_r;
    wire lock_drop = ~lock_req_r & lock_gnt_r;
    wire idle_free = (st_r == ST_IDLE) & ~lock_take & ~lock_drop;
    wire pop = ce & idle_free & fifo_valid;

    // Incoming serial bytes wait here while the engine is busy
    shrm_fifo #(.W($bits(shrm_lnk_t)), .D(FIFO_DEPTH)) u_rx_fifo (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .ce(ce),
        .in_valid(lnk_valid),
        .in_ready(lnk_ready),
        .in_data(lnk_word),
        .out_valid(fifo_valid),
        .out_ready(pop),
        .out_data(fifo_word)
    );

    // Received byte decode
    wire rx_logged = logged_r[w_r.dev];
    wire rx_bcast = (w_r.kind == LK_BCAST);
    wire rx_ident = (w_r.kind == LK_IDENT);
    wire rx_direct = (w_r.kind == LK_DIRECT);
    wire rx_in_wr = rx_bcast & rx_logged & ~lock_gnt_r;
    wire rx_wr = rx_in_wr | rx_ident | (rx_direct & ~lock_gnt_r);
    wire [13:0] rx_addr = rx_bcast ? seg_addr(ADR_DEV_INPUT, w_r.dev, idx_r, 1'b1) :
                          rx_ident ? seg_addr(ADR_DEV_CONFIG, w_r.dev, idx_r, 1'b0) :
                          ADR_DIR_IN + {7'b0, idx_r};
    wire [13:0] tx_addr = own_r ? ADR_BCAST_OUT + {7'b0, idx_r} :
                          seg_addr(ADR_DEV_OUTPUT, dev_r, idx_r, 1'b1);

    // Manager memory request per state
    wire mgr_req = ((st_r == ST_RX) & rx_wr) | (st_r == ST_DEVCHG) | (st_r == ST_TXRD) |
                   (st_r == ST_LOCK) | (st_r == ST_GRANT) | (st_r == ST_UNLOCK);
    wire mgr_we = (st_r != ST_TXRD);
    wire [13:0] mgr_addr = (st_r == ST_RX) ? rx_addr :
                           (st_r == ST_DEVCHG) ? ADR_INT_STATUS + INT_DEV_CHANGE :
                           (st_r == ST_TXRD) ? tx_addr :
                           (st_r == ST_GRANT) ? ADR_INT_STATUS + INT_LOCK_GRANT :
                           ADR_LOCK_STATE;
    wire [7:0] mgr_wdata = (st_r == ST_RX) ? w_r.data :
                           (st_r == ST_UNLOCK) ? FLAG_CLR : FLAG_SET;
    // Host always wins the single memory port; the manager retries next cycle
    wire hst_go = ce & hst_sel;
    wire mgr_go = ce & mgr_req & ~hst_sel;
    wire rx_step = ce & (st_r == ST_RX) & (~rx_wr | mgr_go);

    wire mem_we = hst_go ? hst_wr : (mgr_go & mgr_we);
    wire [13:0] mem_addr = hst_go ? hst_addr : mgr_addr;
    wire [7:0] mem_wdata = hst_go ? hst_wdata : mgr_wdata;

    // Any host address maps to a byte; no region is write protected
    always_ff @(posedge core_clk)
        if (mem_we)
            mem_r[mem_addr] <= mem_wdata;

    always_ff @(posedge core_clk)
        if (!reset_n)
        begin
            hst_q_r <= 8'h00;
            mgr_q_r <= 8'h00;
        end
        else
        begin
            if (hst_go & ~hst_wr)
                hst_q_r <= mem_r[hst_addr];
            if (mgr_go & ~mgr_we)
                mgr_q_r <= mem_r[mgr_addr];
        end

    // Host write snoop for manager interrupts and lockout request
    wire hst_wr_go = hst_go & hst_wr;
    wire [2:0] irq_set;
    assign irq_set[IRQ_HEAD] = hst_wr_go & (hst_addr == ADR_REQ_HEAD);
    assign irq_set[IRQ_CMD] = hst_wr_go & (hst_addr >= ADR_CMD_BLOCK) & (hst_addr <= ADR_CMD_LAST);
    assign irq_set[IRQ_LOCK] = hst_wr_go & (hst_addr == ADR_LOCK_REQ);
    wire [2:0] irq_nxt = irq_set | (irq_src_r & ~(mgr_irq_ack & {3{ce}}));

    always_ff @(posedge core_clk)
        if (!reset_n)
        begin
            irq_src_r <= 3'h0;
            lock_req_r <= 1'b0;
        end
        else
        begin
            irq_src_r <= irq_nxt;
            if (irq_set[IRQ_LOCK])
                lock_req_r <= (hst_wdata != 8'h00);
        end

    // Scan aging decode for the device under test
    wire scan_seen = seen_r[dev_r];
    wire scan_drop = logged_r[dev_r] & ~scan_seen & (miss_r[dev_r] == LOGOUT_MISSES - 2'h1);
    wire dev_end = (dev_r == 5'h1F);
    wire seg_end = (idx_r == 7'h7F);

    always_comb
    begin
        st_nxt = st_r;
        unique case (st_r)
            ST_IDLE:
                if (lock_take)
                    st_nxt = ST_LOCK;
                else if (lock_drop)
                    st_nxt = ST_UNLOCK;
                else if (pop)
                    st_nxt = (fifo_word.kind == LK_SCAN) ? ST_SCAN : ST_RX;
            ST_RX:
                if (rx_step)
                    st_nxt = (rx_ident & w_r.last) ? ST_DEVCHG : ST_IDLE;
            ST_SCAN:
                if (dev_end)
                    st_nxt = (lost_r | scan_drop) ? ST_DEVCHG : (lock_gnt_r ? ST_IDLE : ST_TX);
            ST_DEVCHG:
                if (mgr_go)
                    st_nxt = (lost_r & ~lock_gnt_r) ? ST_TX : ST_IDLE;
            ST_TX:
                if (lock_req_r)
                    st_nxt = ST_IDLE;
                else if (logged_r[dev_r] | dev_end)
                    st_nxt = ST_TXRD;
            ST_TXRD:
                if (mgr_go)
                    st_nxt = ST_TXSEND;
            ST_TXSEND:
                if (tx_ready)
                    st_nxt = ~seg_end ? ST_TXRD : own_r ? ST_IDLE : dev_end ? ST_TXRD : ST_TX;
            ST_LOCK:
                if (mgr_go)
                    st_nxt = ST_GRANT;
            ST_GRANT, ST_UNLOCK:
                if (mgr_go)
                    st_nxt = ST_IDLE;
            default:
                st_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk)
        if (!reset_n)
            st_r <= ST_IDLE;
        else if (ce)
            st_r <= st_nxt;

    // Engine data registers
    always_ff @(posedge core_clk)
        if (!reset_n)
        begin
            w_r <= '0;
            dev_r <= 5'h00;
            idx_r <= 7'h00;
            own_r <= 1'b0;
            lost_r <= 1'b0;
            lock_gnt_r <= 1'b0;
            logged_r <= 32'h0;
            seen_r <= 32'h0;
            login_req_r <= 1'b0;
            login_dev_r <= 5'h00;
            for (int i = 0; i < DEV_COUNT; i++)
                miss_r[i] <= 2'h0;
        end
        else if (ce)
        begin
            login_req_r <= 1'b0;
            if (pop)
                w_r <= fifo_word;
            if (pop & (fifo_word.kind == LK_SCAN))
                dev_r <= 5'h00;
            if (rx_step)
            begin
                idx_r <= w_r.last ? 7'h00 : idx_r + 7'h01;
                if (rx_bcast & w_r.last & rx_logged)
                    seen_r[w_r.dev] <= 1'b1;
                if (rx_bcast & w_r.last & ~rx_logged)
                begin
                    login_req_r <= 1'b1;
                    login_dev_r <= w_r.dev;
                end
                if (rx_ident & w_r.last)
                begin
                    logged_r[w_r.dev] <= 1'b1;
                    seen_r[w_r.dev] <= 1'b1;
                    miss_r[w_r.dev] <= 2'h0;
                    lost_r <= 1'b0;
                end
            end
            if (st_r == ST_SCAN)
            begin
                if (scan_seen)
                    miss_r[dev_r] <= 2'h0;
                else if (logged_r[dev_r])
                    miss_r[dev_r] <= scan_drop ? 2'h0 : miss_r[dev_r] + 2'h1;
                if (scan_drop)
                begin
                    logged_r[dev_r] <= 1'b0;
                    lost_r <= 1'b1;
                end
                if (dev_end)
                begin
                    seen_r <= 32'h0;
                    lost_r <= lost_r | scan_drop;
                    if (~(lost_r | scan_drop))
                        own_r <= 1'b0;
                end
                dev_r <= dev_r + 5'h01;
            end
            if ((st_r == ST_DEVCHG) & mgr_go)
            begin
                lost_r <= 1'b0;
                own_r <= 1'b0;
                dev_r <= 5'h00;
            end
            if ((st_r == ST_TX) & ~lock_req_r & ~logged_r[dev_r])
            begin
                if (dev_end)
                    own_r <= 1'b1;
                else
                    dev_r <= dev_r + 5'h01;
            end
            if ((st_r == ST_TXSEND) & tx_ready)
            begin
                idx_r <= idx_r + 7'h01;
                if (seg_end & own_r)
                    own_r <= 1'b0;
                else if (seg_end & dev_end)
                    own_r <= 1'b1;
                else if (seg_end)
                    dev_r <= dev_r + 5'h01;
            end
            if ((st_r == ST_GRANT) & mgr_go)
                lock_gnt_r <= 1'b1;
            if ((st_r == ST_UNLOCK) & mgr_go)
                lock_gnt_r <= 1'b0;
        end

    assign hst_rdata = hst_q_r;
    assign tx_valid = (st_r == ST_TXSEND);
    assign tx_data = mgr_q_r;
    assign tx_dev = dev_r;
    assign tx_own = own_r;
    assign tx_last = seg_end;
    assign login_req = login_req_r;
    assign login_dev = login_dev_r;
    assign mgr_irq_src = irq_src_r;
    assign mgr_irq = |irq_src_r;
    assign lock_granted = lock_gnt_r;

    // Control tables start at the directed input table and run to the top
    wire mgr_ctl_hit = mgr_go & (mgr_addr >= ADR_DIR_IN);

    AST_HOST_WINS: assert property (@(posedge core_clk) disable iff (!reset_n)
        hst_sel |-> !mgr_go) else $error("manager used port during host access");
    AST_MGR_WAITS: assert property (@(posedge core_clk) disable iff (!reset_n)
        ce && hst_sel && mgr_req |=> st_r == $past(st_r)) else $error("manager access lost in collision");
    AST_LOCK_IRQ: assert property (@(posedge core_clk) disable iff (!reset_n)
        irq_set[IRQ_LOCK] |=> irq_src_r[IRQ_LOCK] && mgr_irq) else $error("lockout write gave no irq");
    AST_IRQ_PENDING: assert property (@(posedge core_clk) disable iff (!reset_n)
        irq_src_r[IRQ_CMD] && !(ce && mgr_irq_ack[IRQ_CMD]) |=> irq_src_r[IRQ_CMD])
        else $error("command irq dropped before ack");
    AST_LOCKOUT_QUIET: assert property (@(posedge core_clk) disable iff (!reset_n)
        lock_gnt_r |-> !mgr_ctl_hit) else $error("control table touched under lockout");
    AST_LOGOUT_THIRD: assert property (@(posedge core_clk) disable iff (!reset_n)
        ce && st_r == ST_SCAN && scan_drop |=> !logged_r[$past(dev_r)] ##0 lost_r)
        else $error("device not logged out after three misses");
    AST_TX_LOGGED: assert property (@(posedge core_clk) disable iff (!reset_n)
        tx_valid && !tx_own |-> logged_r[tx_dev]) else $error("output sent to logged-out device");
    AST_LOGIN_UNLISTED: assert property (@(posedge core_clk) disable iff (!reset_n)
        login_req |-> !logged_r[login_dev] && $past(st_r) == ST_RX) else $error("login for listed device");
    AST_IDENT_LOGS_IN: assert property (@(posedge core_clk) disable iff (!reset_n)
        rx_step && rx_ident && w_r.last |=> logged_r[$past(w_r.dev)] && st_r == ST_DEVCHG)
        else $error("identification did not log in");
    AST_INPUT_SEGMENT: assert property (@(posedge core_clk) disable iff (!reset_n)
        mgr_go && st_r == ST_RX && rx_in_wr |-> mgr_addr[13:7] == {ADR_DEV_INPUT[13:12], w_r.dev})
        else $error("broadcast byte in wrong segment");
    AST_GRANT_FLAG: assert property (@(posedge core_clk) disable iff (!reset_n)
        $rose(lock_gnt_r) |-> $past(st_r) == ST_GRANT && lock_req_r) else $error("grant without request");
endmodule : shrm_core

`default_nettype wire

/* test/shrm_host_model.sv */
`timescale 1ns/1ps
`default_nettype none

module shrm_host_model (
    input wire logic core_clk,
    output logic hst_sel,
    output logic hst_wr,
    output logic [shrm_pkg::SRAM_AW-1:0] hst_addr,
    output logic [7:0] hst_wdata,
    input wire logic [7:0] hst_rdata
);
    import shrm_pkg::*;

    initial
    begin
        hst_sel = 1'b0;
        hst_wr = 1'b0;
        hst_addr = 14'h0000;
        hst_wdata = 8'h00;
    end

    // One byte access; released lines show the inverse of their last value
    task automatic acc(input logic w, input logic [13:0] a, input logic [7:0] d);
        @(negedge core_clk);
        hst_sel = 1'b1;
        hst_wr = w;
        hst_addr = a;
        hst_wdata = d;
        @(negedge core_clk);
        hst_sel = 1'b0;
        hst_wr = ~w;
        hst_addr = ~a;
        hst_wdata = ~d;
    endtask : acc

    task automatic rd(input logic [13:0] a, output logic [7:0] d);
        acc(1'b0, a, 8'h00);
        @(negedge core_clk);
        d = hst_rdata;
    endtask : rd
endmodule : shrm_host_model

`default_nettype wire

/* test/shrm_core_test.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) \
    begin \
        checked++; \
        if ((g) !== (e)) \
        begin \
            failures++; \
            $display("Error %s expected %h seen %h", nm, e, g); \
        end \
    end

module shrm_core_test;
    import shrm_pkg::*;
    logic core_clk, reset_n, ce, hst_sel, hst_wr, lnk_valid, lnk_ready, tx_valid, tx_ready, tx_own, tx_last;
    logic login_req, mgr_irq, lock_granted;
    logic [13:0] hst_addr;
    logic [7:0] hst_wdata, hst_rdata, tx_data, rd;
    logic [4:0] tx_dev, login_dev, login_last;
    logic [2:0] mgr_irq_src, mgr_irq_ack;
    shrm_lnk_t lnk_word;
    logic [14:0] txq[$];
    int failures = 0;
    int checked = 0;
    int logins = 0;
    localparam logic [13:0] SEG5 = 14'd640;
    localparam logic [13:0] DEVCHG = ADR_INT_STATUS + INT_DEV_CHANGE;

    shrm_core #(.FIFO_DEPTH(8)) dut (.core_clk(core_clk), .reset_n(reset_n), .ce(ce), .hst_sel(hst_sel),
        .hst_wr(hst_wr), .hst_addr(hst_addr), .hst_wdata(hst_wdata), .hst_rdata(hst_rdata),
        .lnk_valid(lnk_valid), .lnk_ready(lnk_ready), .lnk_word(lnk_word), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .tx_data(tx_data), .tx_dev(tx_dev), .tx_own(tx_own), .tx_last(tx_last),
        .login_req(login_req), .login_dev(login_dev), .mgr_irq(mgr_irq), .mgr_irq_src(mgr_irq_src),
        .mgr_irq_ack(mgr_irq_ack), .lock_granted(lock_granted));
    shrm_host_model host (.core_clk(core_clk), .hst_sel(hst_sel), .hst_wr(hst_wr), .hst_addr(hst_addr),
        .hst_wdata(hst_wdata), .hst_rdata(hst_rdata));

    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    always @(posedge core_clk)
    begin
        if (tx_valid && tx_ready)
            txq.push_back({tx_own, tx_last, tx_dev, tx_data});
        if (login_req)
        begin
            logins++;
            login_last <= login_dev;
        end
    end

    // Serial side stalls every other cycle
    always @(negedge core_clk)
        tx_ready <= ~tx_ready;

    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : final_report

    task automatic guard(input int w, input int lim);
        if (w >= lim)
        begin
            `CHK("timeout", 1'b0, 1'b1)
            final_report();
        end
    endtask : guard

    task automatic send(input shrm_kind_t k, input logic [4:0] dv, input int n, input logic [7:0] s);
        int w;
        @(negedge core_clk);
        lnk_valid = 1'b1;
        for (int i = 0; i < n; i++)
        begin
            lnk_word = '{k, dv, i == n - 1, s + 8'(i)};
            for (w = 0; lnk_ready !== 1'b1 && w < 200; w++)
                @(negedge core_clk);
            guard(w, 200);
            @(negedge core_clk);
        end
        lnk_valid = 1'b0;
        lnk_word = ~lnk_word;
    endtask : send

    task automatic poll(input logic [13:0] a, input logic [7:0] e, input string nm);
        for (int i = 0; i < 30; i++)
        begin
            host.rd(a, rd);
            if (rd === e)
                break;
        end
        `CHK(nm, e, rd)
    endtask : poll

    task automatic ack(input logic [2:0] v);
        @(negedge core_clk);
        mgr_irq_ack = v;
        @(negedge core_clk);
        mgr_irq_ack = 3'h0;
    endtask : ack

    task automatic wait_scan(output int n);
        int w;
        txq.delete();
        send(LK_SCAN, 5'd0, 1, 8'h00);
        for (w = 0; !(txq.size() > 0 && txq[$][14] && txq[$][13]) && w < 5000; w++)
            @(negedge core_clk);
        guard(w, 5000);
        n = txq.size();
    endtask : wait_scan

    task automatic t_ram();
        logic [13:0] a[4] = '{14'h0000, ADR_RESERVED, 14'h1E07, 14'h3FFF};
        foreach (a[i])
            host.acc(1'b1, a[i], 8'hA5 ^ 8'(i));
        foreach (a[i])
            poll(a[i], 8'hA5 ^ 8'(i), "ram byte");
    endtask : t_ram

    task automatic t_irq();
        host.acc(1'b1, ADR_REQ_TAIL, 8'h11);
        `CHK("irq idle", 3'h0, mgr_irq_src)
        host.acc(1'b1, ADR_REQ_HEAD, 8'h11);
        host.acc(1'b1, ADR_CMD_LAST, 8'h22);
        host.acc(1'b1, ADR_LOCK_REQ, 8'h00);
        host.acc(1'b1, ADR_CMD_BLOCK, 8'h33);
        `CHK("irq sources", 3'h7, mgr_irq_src)
        ack(3'h3);
        `CHK("irq one event", 3'h4, mgr_irq_src)
        ack(3'h4);
        `CHK("irq line", 1'b0, mgr_irq)
        @(negedge core_clk);
        ce = 1'b0;
        host.acc(1'b1, ADR_REQ_HEAD, 8'h44);
        ce = 1'b1;
        `CHK("irq frozen", 3'h0, mgr_irq_src)
        poll(ADR_REQ_HEAD, 8'h11, "frozen write");
    endtask : t_irq

    task automatic t_login();
        int w;
        host.acc(1'b1, ADR_DEV_INPUT + SEG5, 8'hEE);
        host.acc(1'b1, DEVCHG, FLAG_CLR);
        send(LK_BCAST, 5'd5, 4, 8'h40);
        for (w = 0; logins == 0 && w < 50; w++)
            @(negedge core_clk);
        guard(w, 50);
        `CHK("login dev", 5'd5, login_last)
        poll(ADR_DEV_INPUT + SEG5, 8'hEE, "input before login");
        send(LK_IDENT, 5'd5, 8, 8'h80);
        poll(DEVCHG, FLAG_SET, "login flag");
        poll(ADR_DEV_CONFIG + 14'd47, 8'h87, "config seg");
        send(LK_BCAST, 5'd5, 4, 8'h40);
        poll(ADR_DEV_INPUT + SEG5 + 14'd3, 8'h43, "input seg");
        send(LK_DIRECT, 5'd9, 4, 8'h60);
        poll(ADR_DIR_IN + 14'd2, 8'h62, "directed in");
    endtask : t_login

    task automatic t_scan();
        int n;
        for (int i = 0; i < 128; i++)
        begin
            host.acc(1'b1, ADR_DEV_OUTPUT + SEG5 + 14'(i), 8'(i) ^ 8'h5A);
            host.acc(1'b1, ADR_BCAST_OUT + 14'(i), 8'(i) ^ 8'hC3);
        end
        wait_scan(n);
        `CHK("scan bytes", 256, n)
        `CHK("seg first", {2'b00, 5'd5, 8'h5A}, txq[0])
        `CHK("seg last", {2'b01, 5'd5, 8'h25}, txq[127])
        `CHK("own first", {1'b1, 8'hC3}, {txq[128][14], txq[128][7:0]})
        `CHK("own last", {2'b11, 8'hBC}, {txq[255][14:13], txq[255][7:0]})
    endtask : t_scan

    task automatic t_lock();
        int w;
        host.acc(1'b1, ADR_LOCK_REQ, 8'h01);
        for (w = 0; lock_granted !== 1'b1 && w < 2000; w++)
            @(negedge core_clk);
        guard(w, 2000);
        poll(ADR_LOCK_STATE, FLAG_SET, "lock state");
        poll(ADR_INT_STATUS + INT_LOCK_GRANT, FLAG_SET, "grant flag");
        send(LK_BCAST, 5'd5, 4, 8'h90);
        send(LK_DIRECT, 5'd9, 4, 8'h90);
        repeat (30) @(negedge core_clk);
        poll(ADR_DEV_INPUT + SEG5 + 14'd3, 8'h43, "locked input");
        poll(ADR_DIR_IN + 14'd2, 8'h62, "locked directed");
        host.acc(1'b1, ADR_LOCK_REQ, 8'h00);
        poll(ADR_LOCK_STATE, FLAG_CLR, "unlock state");
        `CHK("grant off", 1'b0, lock_granted)
        send(LK_BCAST, 5'd5, 4, 8'hB0);
        poll(ADR_DEV_INPUT + SEG5 + 14'd1, 8'hB1, "resumed input");
    endtask : t_lock

    task automatic t_logout();
        int n;
        int l;
        wait_scan(n);
        host.acc(1'b1, DEVCHG, FLAG_CLR);
        wait_scan(n);
        wait_scan(n);
        `CHK("two misses", 256, n)
        poll(DEVCHG, FLAG_CLR, "still in");
        wait_scan(n);
        `CHK("no output after logout", 128, n)
        poll(DEVCHG, FLAG_SET, "loss flag");
        l = logins;
        send(LK_BCAST, 5'd5, 4, 8'hD0);
        for (n = 0; logins == l && n < 50; n++)
            @(negedge core_clk);
        guard(n, 50);
        `CHK("relogin", 5'd5, login_last)
    endtask : t_logout

    initial
    begin
        reset_n = 1'b0;
        ce = 1'b1;
        lnk_valid = 1'b0;
        lnk_word = '0;
        tx_ready = 1'b0;
        mgr_irq_ack = 3'h0;
        repeat (20) @(negedge core_clk);
        reset_n = 1'b1;
        `CHK("ready after reset", 1'b1, lnk_ready)
        t_ram();
        t_irq();
        t_login();
        t_scan();
        t_lock();
        t_logout();
        final_report();
    end
endmodule : shrm_core_test

`default_nettype wire
